// ==== hdl/cfg_bank_pkg.sv ====
// Constants shared by the configuration register bank and its serial receiver
package cfg_bank_pkg;

    // ----------------------------------------------------------------
    // Serial word layout
    // ----------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int ADDR_BITS = 4;
    localparam int DATA_BITS = 12;
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 12;
    localparam int DATA_MSB = 11;
    localparam int DATA_LSB = 0;
    localparam int NUM_ADDR = 16;
    localparam int SAMPLE_BITS = 14;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_CONFIG_WORD_0 = 4'h0;
    localparam logic [3:0] ADDR_CONFIG_WORD_1 = 4'h1;
    localparam logic [3:0] ADDR_CONFIG_WORD_9 = 4'h9;
    localparam logic [3:0] ADDR_CONFIG_WORD_10 = 4'hA;
    localparam logic [3:0] ADDR_CONFIG_WORD_11 = 4'hB;
    localparam logic [3:0] ADDR_CONFIG_WORD_12 = 4'hC;
    localparam logic [3:0] ADDR_CONFIG_WORD_13 = 4'hD;
    localparam logic [3:0] ADDR_CONFIG_WORD_14 = 4'hE;
    localparam logic [3:0] ADDR_CONFIG_WORD_15 = 4'hF;

    // Implemented addresses, one bit per address
    localparam logic [15:0] ADDR_IMPL_MASK = 16'hFE03;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [11:0] RESET_ZERO = 12'h000;
    localparam logic [11:0] RESET_CONFIG_WORD_14 = 12'h804;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int RST_PULSE_MIN_NS = 2000;
    // Least time rounds up to whole cycles
    localparam int RST_PULSE_MIN_CYC = (RST_PULSE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int RST_CNT_BITS = 8;

    // Receiver states
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_SHIFT = 2'b01,
        RX_BAD = 2'b10
    } rx_state_e;

endpackage

// ==== hdl/cfg_wr_if.sv ====
// Write strobe carrier from serial receiver to register bank
`timescale 1ns/1ps
`default_nettype none
interface cfg_wr_if;
    logic wr_stb;
    logic [3:0] wr_addr;
    logic [11:0] wr_data;

    modport rx
    (
        output wr_stb,
        output wr_addr,
        output wr_data
    );
    modport bank
    (
        input wr_stb,
        input wr_addr,
        input wr_data
    );
endinterface
`default_nettype wire

// ==== hdl/cfg_serial_rx.sv ====
// Three-wire serial receiver turning 16-bit words into register writes
`timescale 1ns/1ps
`default_nettype none
module cfg_serial_rx
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Serial pins, already synchronised
    input wire logic sen_n_i,
    input wire logic sclk_i,
    input wire logic sdata_i,
    // Write strobe out
    cfg_wr_if.rx wr
);

    // ----------------------------------------------------------------
    // Edge detection on synchronised pins
    // ----------------------------------------------------------------
    logic sclk_d_reg;
    logic sen_n_d_reg;
    logic [15:0] shift_reg;
    logic [15:0] shift_next;
    logic [4:0] count_reg;
    logic [4:0] count_next;
    cfg_bank_pkg::rx_state_e state_reg;
    cfg_bank_pkg::rx_state_e state_next;
    logic stb_next;
    wire sclk_rise = sclk_i & ~sclk_d_reg;
    wire frame_end = sen_n_i & ~sen_n_d_reg;
    wire word_full = (count_reg == 5'(cfg_bank_pkg::WORD_BITS));

    // Frame sequencing; a word with a wrong bit count is dropped
    always_comb
    begin
        state_next = state_reg;
        shift_next = shift_reg;
        count_next = count_reg;
        stb_next = 1'b0;
        case (state_reg)
            cfg_bank_pkg::RX_IDLE:
            begin
                if (!sen_n_i)
                begin
                    state_next = cfg_bank_pkg::RX_SHIFT;
                    count_next = 5'h00;
                end
            end
            cfg_bank_pkg::RX_SHIFT:
            begin
                if (frame_end)
                begin
                    stb_next = word_full;
                    state_next = cfg_bank_pkg::RX_IDLE;
                end
                else if (sclk_rise)
                begin
                    shift_next = {shift_reg[14:0], sdata_i}; // MSB first
                    if (word_full)
                        state_next = cfg_bank_pkg::RX_BAD; // Too many bits
                    else
                        count_next = count_reg + 5'h01;
                end
            end
            cfg_bank_pkg::RX_BAD:
            begin
                if (sen_n_i)
                    state_next = cfg_bank_pkg::RX_IDLE;
            end
            default:
            begin
                state_next = cfg_bank_pkg::RX_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state_reg <= cfg_bank_pkg::RX_IDLE;
            shift_reg <= 16'h0000;
            count_reg <= 5'h00;
            sclk_d_reg <= 1'b0;
            sen_n_d_reg <= 1'b1;
            wr.wr_stb <= 1'b0;
            wr.wr_addr <= 4'h0;
            wr.wr_data <= 12'h000;
        end
        else
        begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            count_reg <= count_next;
            sclk_d_reg <= sclk_i;
            sen_n_d_reg <= sen_n_i;
            wr.wr_stb <= stb_next;
            wr.wr_addr <= shift_reg[cfg_bank_pkg::ADDR_MSB:cfg_bank_pkg::ADDR_LSB];
            wr.wr_data <= shift_reg[cfg_bank_pkg::DATA_MSB:cfg_bank_pkg::DATA_LSB];
        end
    end

endmodule
`default_nettype wire

// ==== hdl/cfg_bank_top.sv ====
// Configuration register bank with serial writes and reset-pin defaults
`timescale 1ns/1ps
`default_nettype none
module cfg_bank_top
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Device reset pin, active high
    input wire logic reset_pin_i,
    // Three-wire serial programming pins
    input wire logic sen_n_i,
    input wire logic sclk_i,
    input wire logic sdata_i,
    // Conversion data path
    input wire logic [13:0] sample_i,
    output logic [13:0] data_o,
    // Converter core reset and configuration
    output logic core_reset_o,
    output logic [191:0] cfg_words_o
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;

    // Two flops on every pin; first stage feeds only the second
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            sync1_reg <= 4'h2;
            sync2_reg <= 4'h2;
        end
        else
        begin
            sync1_reg <= {reset_pin_i, sdata_i, sen_n_i, sclk_i};
            sync2_reg <= sync1_reg;
        end
    end

    wire pin_rst_s = sync2_reg[3];

    // ----------------------------------------------------------------
    // Reset pulse qualification
    // ----------------------------------------------------------------
    logic [7:0] rst_cnt_reg;
    logic [7:0] rst_cnt_next;
    localparam logic [7:0] RST_MIN = 8'(cfg_bank_pkg::RST_PULSE_MIN_CYC);
    // Short glitches on the pin are ignored until the minimum width is seen
    wire rst_qual = pin_rst_s && (rst_cnt_reg == RST_MIN);

    // Saturating high-time counter, cleared when the pin falls
    assign rst_cnt_next = !pin_rst_s ? 8'h00 :
                          (rst_cnt_reg == RST_MIN) ? rst_cnt_reg : rst_cnt_reg + 8'h01;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            rst_cnt_reg <= 8'h00;
        else
            rst_cnt_reg <= rst_cnt_next;
    end

    // ----------------------------------------------------------------
    // Serial receiver
    // ----------------------------------------------------------------
    cfg_wr_if wr_bus ();

    cfg_serial_rx u_rx
    (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .sen_n_i(sync2_reg[1]),
        .sclk_i(sync2_reg[0]),
        .sdata_i(sync2_reg[2]),
        .wr(wr_bus.rx)
    );

    // ----------------------------------------------------------------
    // Register bank
    // ----------------------------------------------------------------
    // Unimplemented addresses keep zero; a write there is ignored
    genvar gi;
    generate
        for (gi = 0; gi < cfg_bank_pkg::NUM_ADDR; gi++)
        begin : g_word
            localparam logic [3:0] MY_ADDR = 4'(gi);
            localparam logic [11:0] DEFVAL = (MY_ADDR == cfg_bank_pkg::ADDR_CONFIG_WORD_14) ?
                                             cfg_bank_pkg::RESET_CONFIG_WORD_14 : cfg_bank_pkg::RESET_ZERO;
            if (cfg_bank_pkg::ADDR_IMPL_MASK[gi])
            begin : g_impl
                wire hit = wr_bus.wr_stb && (wr_bus.wr_addr == MY_ADDR);
                // Defaults on system reset or a qualified pin pulse
                always_ff @(posedge clk_sys_i)
                begin
                    if (rst_i || rst_qual)
                        cfg_words_o[gi*12 +: 12] <= DEFVAL;
                    else if (hit)
                        cfg_words_o[gi*12 +: 12] <= wr_bus.wr_data; // Whole word replaced
                end
            end
            else
            begin : g_none
                always_ff @(posedge clk_sys_i)
                begin
                    cfg_words_o[gi*12 +: 12] <= cfg_bank_pkg::RESET_ZERO;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Converter reset and data outputs
    // ----------------------------------------------------------------
    // Core held in reset and data forced low during a qualified pulse
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            core_reset_o <= 1'b1;
            data_o <= 14'h0000;
        end
        else
        begin
            core_reset_o <= rst_qual;
            data_o <= rst_qual ? 14'h0000 : sample_i;
        end
    end

endmodule
`default_nettype wire

// ==== verif/cfg_bank_asserts.sv ====
// Port assertions for the config register bank
`timescale 1ns/1ps
`default_nettype none
module cfg_bank_asserts
(
    // Watched ports
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic reset_pin_i,
    input wire logic sen_n_i,
    input wire logic [13:0] data_o,
    input wire logic core_reset_o,
    input wire logic [191:0] cfg_words_o
);
    localparam logic [191:0] DEF = {12'h000, 12'h804, 168'h0};
    logic [7:0] pin_cnt_reg;

    // Pin-high run length, saturating so long pulses stay visible
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_pin_i)
            pin_cnt_reg <= 8'h00;
        else if (pin_cnt_reg != 8'hFF)
            pin_cnt_reg <= pin_cnt_reg + 8'h01;
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    chk_rst_defaults: assert property (disable iff (1'b0) rst_i |=> cfg_words_o == DEF)
        else $error("defaults not loaded by reset");
    chk_rst_core: assert property (disable iff (1'b0) rst_i |=> core_reset_o && data_o == 14'h0000)
        else $error("core reset or data wrong in reset");
    chk_pin_reload: assert property (pin_cnt_reg == 8'h78 |-> core_reset_o && cfg_words_o == DEF)
        else $error("long pin pulse did not reload");
    chk_pin_min: assert property ($rose(core_reset_o) |-> pin_cnt_reg >= 8'h64)
        else $error("pin pulse acted too early");
    chk_pin_data: assert property (core_reset_o && $past(core_reset_o) |-> data_o == 14'h0000)
        else $error("data not low in core reset");
    chk_write_gap: assert property ($changed(cfg_words_o) && !core_reset_o |-> sen_n_i && $past(sen_n_i, 2))
        else $error("config changed outside a write");
    chk_frame_quiet: assert property (!sen_n_i [*6] |-> $stable(cfg_words_o))
        else $error("config moved inside a frame");
    chk_unmapped_zero: assert property (cfg_words_o[107:24] == 84'h0)
        else $error("unmapped word not zero");
    chk_e_default: assert property ($fell(core_reset_o) |-> cfg_words_o[179:168] == 12'h804)
        else $error("word 14 default wrong");
endmodule

bind cfg_bank_top cfg_bank_asserts chk (.clk_sys_i, .rst_i, .reset_pin_i, .sen_n_i, .data_o, .core_reset_o,
    .cfg_words_o);
`default_nettype wire

// ==== verif/cfg_host_model.sv ====
// Host model driving the three-wire programming pins
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model
(
    // Clock
    input wire logic clk_sys_i,
    // Serial pins
    output logic sen_n_o,
    output logic sclk_o,
    output logic sdata_o
);
    // Idle: enable off, serial clock parked low
    initial
    begin
        sen_n_o = 1'b1;
        sclk_o = 1'b0;
        sdata_o = 1'b0;
    end

    // Top nbits of a word, MSB first; other counts make bad frames, bits past the word are zero
    task automatic send(input logic [15:0] w, input int nbits);
        @(negedge clk_sys_i);
        sen_n_o = 1'b0;
        for (int i = 15; i > 15 - nbits; i--)
        begin
            sdata_o = (i >= 0) ? w[i] : 1'b0;
            repeat (4) @(negedge clk_sys_i);
            sclk_o = 1'b1;
            repeat (4) @(negedge clk_sys_i);
            sclk_o = 1'b0;
        end
        repeat (4) @(negedge clk_sys_i);
        sen_n_o = 1'b1;
        sdata_o = ~sdata_o; // Released line must not show the last bit
        repeat (8) @(negedge clk_sys_i);
    endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the config register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic reset_pin_i = 1'b0;
    logic [13:0] sample_i = 14'h0000;
    logic sen_n_i;
    logic sclk_i;
    logic sdata_i;
    logic [13:0] data_o;
    logic core_reset_o;
    logic [191:0] cfg_words_o;
    logic [11:0] exp_w [16];
    logic [206:0] exp_q [$];
    logic [3:0] seq [9] = '{4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'h0, 4'h1, 4'hF};
    int fail_count = 0;
    int tests_run = 0;
    int seed = 78;
    event chk_ev;

    always #10 clk_sys_i = ~clk_sys_i;

    cfg_host_model host (.clk_sys_i, .sen_n_o(sen_n_i), .sclk_o(sclk_i), .sdata_o(sdata_i));
    cfg_bank_top dut (.clk_sys_i, .rst_i, .reset_pin_i, .sen_n_i, .sclk_i, .sdata_i, .sample_i, .data_o,
        .core_reset_o, .cfg_words_o);

    task automatic check(input logic [206:0] seen, input logic [206:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t outputs %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Expected bank image from the model words
    task automatic note(input logic core, input logic [13:0] d);
        logic [191:0] v;
        for (int a = 0; a < 16; a++)
            v[a*12 +: 12] = exp_w[a];
        exp_q.push_back({core, d, v});
        -> chk_ev;
    endtask

    task automatic defaults();
        foreach (exp_w[a])
            exp_w[a] = 12'h000;
        exp_w[14] = 12'h804;
    endtask

    // One serial write, unmapped addresses leave the model alone
    task automatic wr(input logic [15:0] w);
        sample_i = 14'($random(seed));
        host.send(w, 16);
        if (cfg_bank_pkg::ADDR_IMPL_MASK[w[15:12]])
            exp_w[w[15:12]] = w[11:0];
        repeat (6) @(negedge clk_sys_i);
        note(1'b0, sample_i);
    endtask

    // Oldest note against the outputs, once settled
    always @(chk_ev)
        check({core_reset_o, data_o, cfg_words_o}, exp_q.pop_front());

    initial
    begin
        defaults();
        repeat (12) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        note(1'b0, sample_i);
        for (int a = 0; a < 16; a++)
            wr({a[3:0], 12'($random(seed))});
        host.send(16'h9ABC, 15);
        note(1'b0, sample_i);
        host.send(16'h1555, 17);
        note(1'b0, sample_i);
        $display("writes and bad frame done");
        foreach (seq[i])
            wr({seq[i], (seq[i] == 4'hE) ? 12'h804 : 12'h000});
        $display("software defaults done");
        wr(16'hE123);
        reset_pin_i = 1'b1;
        repeat (50) @(negedge clk_sys_i);
        reset_pin_i = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        note(1'b0, sample_i);
        reset_pin_i = 1'b1;
        repeat (130) @(negedge clk_sys_i);
        defaults();
        note(1'b1, 14'h0000);
        repeat (20) @(negedge clk_sys_i);
        reset_pin_i = 1'b0;
        repeat (8) @(negedge clk_sys_i);
        note(1'b0, sample_i);
        $display("pin reset done");
        wr(16'h1FFF);
        rst_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        defaults();
        note(1'b1, 14'h0000);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        note(1'b0, sample_i);
        $display("second reset done");
        results();
    end

    // Watchdog well past the expected run time
    initial
    begin
        #1_000_000;
        fail_count++;
        results();
    end
endmodule
`default_nettype wire
